// ### hw/adc_readout_pkg.sv
// Constants for the serial readout timing block
package adc_readout_pkg;
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned MOD_MIN_HZ = 500_000;
  localparam int unsigned MOD_MAX_HZ = 20_000_000;
  // Half modulator period in system cycles, bounded so the modulator rate stays in range
  localparam int unsigned HALF_MIN_INT = (CLK_HZ + 2 * MOD_MAX_HZ - 1) / (2 * MOD_MAX_HZ);
  localparam int unsigned HALF_MAX_INT = CLK_HZ / (2 * MOD_MIN_HZ);
  localparam logic [7:0] HALF_MIN = 8'(HALF_MIN_INT);
  localparam logic [7:0] HALF_MAX = 8'(HALF_MAX_INT);

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_MOD_HALF = 8'h04;
  localparam logic [7:0] OFS_PERIOD = 8'h08;
  localparam logic [7:0] OFS_RESULT = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;

  // Control fields
  localparam int CTRL_ENABLE = 0;
  localparam int CTRL_RATE = 1;
  localparam int CTRL_DIVIDE = 2;
  localparam int CTRL_POLARITY = 3;
  localparam int CTRL_DEC32 = 4;
  localparam int CTRL_CHAIN_LSB = 8;
  localparam int CTRL_CHAIN_W = 4;

  // Reset values
  localparam logic [31:0] CTRL_RESET = 32'h0000_0100;
  localparam logic [7:0] MOD_HALF_RESET = 8'h04;
  localparam logic [15:0] PERIOD_RESET = 16'h0040;
  localparam logic [31:0] RESULT_RESET = 32'h0000_0000;

  // Frame timing in serial clock periods
  localparam logic [15:0] PERIOD_MIN = 16'h0040;
  localparam logic [15:0] WORD_BITS = 16'h0020;
  localparam logic [15:0] LAST_BIT = 16'h001f;
  localparam logic [15:0] READY_END = 16'h0001;
  localparam logic [15:0] CHAIN_FIRST = 16'h0011;
endpackage

// ### hw/sclk_if.sv
// Link between readout control and serial clock generator
`timescale 1ns/100ps
interface sclk_if;
  logic run;
  logic [8:0] phase_len;
  logic sco;
  logic rise;
  logic fall;
  modport gen (input run, input phase_len, output sco, output rise, output fall);
  modport user (output run, output phase_len, input sco, input rise, input fall);
endinterface

// ### hw/sclk_gen.sv
// Serial clock generator built from the modulator clock phase length
`timescale 1ns/100ps
module sclk_gen (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Clock link
  sclk_if.gen lnk
);
  logic [8:0] cnt;
  logic sco;
  logic rise;
  logic fall;
  wire phase_end = (cnt >= lnk.phase_len - 9'h001);

  always_ff @(posedge clk_i) begin
    if (rst_i || !lnk.run) begin
      cnt <= 9'h000;
      sco <= 1'b0;
      rise <= 1'b0;
      fall <= 1'b0;
    end else begin
      cnt <= phase_end ? 9'h000 : cnt + 9'h001;
      sco <= phase_end ? ~sco : sco;
      rise <= phase_end && !sco;
      fall <= phase_end && sco;
    end
  end

  assign lnk.sco = sco;
  assign lnk.rise = rise;
  assign lnk.fall = fall;
endmodule

// ### hw/adc_readout.sv
// Serial readout timing of the converter output port with a Wishbone register file
//
// Register access over Wishbone and the register offsets were left to the implementer.
`timescale 1ns/100ps
module adc_readout (
  // System
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Serial port pins
  input wire logic frame_sync_in_i,
  input wire logic serial_data_in_i,
  output logic serial_clock_o,
  output logic result_ready_out_o,
  output logic frame_sync_out_o,
  output logic chain_marker_out_o,
  output logic serial_data_out_o
);
  sclk_if lnk ();

  logic [31:0] ctrl;
  logic [7:0] mod_half;
  logic [15:0] period;
  logic [31:0] result;
  logic [15:0] frames;
  logic ack;
  logic [31:0] rdata;

  // Register access
  wire req = cyc_i && stb_i && !ack;
  wire wr = req && we_i;
  wire [31:0] wmask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
  wire hit_ctrl = (adr_i == adc_readout_pkg::OFS_CTRL);
  wire hit_half = (adr_i == adc_readout_pkg::OFS_MOD_HALF);
  wire hit_period = (adr_i == adc_readout_pkg::OFS_PERIOD);
  wire hit_result = (adr_i == adc_readout_pkg::OFS_RESULT);
  wire hit_status = (adr_i == adc_readout_pkg::OFS_STATUS);
  wire [31:0] next_ctrl = (ctrl & ~wmask) | (dat_i & wmask);
  wire [31:0] half_word = {24'h000000, mod_half};
  wire [31:0] next_half_word = (half_word & ~wmask) | (dat_i & wmask);
  wire [31:0] period_word = {16'h0000, period};
  wire [31:0] next_period_word = (period_word & ~wmask) | (dat_i & wmask);
  wire [31:0] next_result = (result & ~wmask) | (dat_i & wmask);

  // Mode fields
  wire enable = ctrl[adc_readout_pkg::CTRL_ENABLE];
  wire rate_sel = ctrl[adc_readout_pkg::CTRL_RATE];
  wire divide_sel = ctrl[adc_readout_pkg::CTRL_DIVIDE];
  wire polarity_sel = ctrl[adc_readout_pkg::CTRL_POLARITY];
  wire dec32 = ctrl[adc_readout_pkg::CTRL_DEC32];
  wire [adc_readout_pkg::CTRL_CHAIN_W-1:0] chain_count =
    ctrl[adc_readout_pkg::CTRL_CHAIN_LSB +: adc_readout_pkg::CTRL_CHAIN_W];

  // Modulator half period, held inside its legal range
  wire [7:0] half_eff = (mod_half < adc_readout_pkg::HALF_MIN) ? adc_readout_pkg::HALF_MIN :
    (mod_half > adc_readout_pkg::HALF_MAX) ? adc_readout_pkg::HALF_MAX : mod_half;
  wire fast = rate_sel && !divide_sel;
  assign lnk.phase_len = fast ? {1'b0, half_eff} : {half_eff, 1'b0};
  assign lnk.run = enable;

  sclk_gen u_sclk (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .lnk(lnk)
  );

  // Edge roles: when polarity_sel is set, the pin inversion below turns these into swapped pin edges
  wire launch = lnk.rise;
  wire sample = lnk.fall;
  wire fso_forced_low = dec32 && !(rate_sel && !divide_sel);

  // Pin synchronisers
  logic fsi_meta;
  logic fsi_sync;
  logic fsi_prev;
  logic sdi_meta;
  logic sdi_sync;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fsi_meta <= 1'b1;
      fsi_sync <= 1'b1;
      sdi_meta <= 1'b0;
      sdi_sync <= 1'b0;
    end else begin
      fsi_meta <= frame_sync_in_i;
      fsi_sync <= fsi_meta;
      sdi_meta <= serial_data_in_i;
      sdi_sync <= sdi_meta;
    end
  end

  // Frame sync input request, held until the next launch edge
  logic resync;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fsi_prev <= 1'b1;
      resync <= 1'b0;
    end else begin
      fsi_prev <= fsi_sync;
      if (fsi_prev && !fsi_sync) begin
        resync <= 1'b1;
      end else if (launch) begin
        resync <= 1'b0;
      end
    end
  end

  // Serial period counter
  logic [15:0] cnt;
  logic [31:0] shreg;
  logic result_ready_out;
  logic frame_sync_out;
  logic cmark;
  logic serial_data_out;
  logic active;

  wire [15:0] period_eff = (period < adc_readout_pkg::PERIOD_MIN) ?
    adc_readout_pkg::PERIOD_MIN : period;
  wire wrap = (cnt >= period_eff - 16'h0001) || resync;
  wire [15:0] next_cnt = wrap ? 16'h0000 : cnt + 16'h0001;
  wire [15:0] chain_off = next_cnt - adc_readout_pkg::CHAIN_FIRST;
  wire chain_hit = (next_cnt >= adc_readout_pkg::CHAIN_FIRST) && (chain_off[3:0] == 4'h0) &&
    (chain_off[15:4] < {8'h00, chain_count});
  wire in_word = (next_cnt < adc_readout_pkg::WORD_BITS);
  wire [31:0] next_shreg = (next_cnt == 16'h0000) ? result : {shreg[30:0], 1'b0};

  always_ff @(posedge clk_i) begin
    if (rst_i || !enable) begin
      cnt <= 16'hffff;
      shreg <= 32'h0000_0000;
      result_ready_out <= 1'b1;
      frame_sync_out <= 1'b1;
      cmark <= 1'b1;
      serial_data_out <= 1'b0;
      active <= 1'b0;
    end else begin
      if (launch) begin
        cnt <= next_cnt;
        shreg <= next_shreg;
        result_ready_out <= (next_cnt != 16'h0000);
        cmark <= !chain_hit;
        serial_data_out <= in_word ? next_shreg[31] : sdi_sync;
        if (next_cnt == 16'h0000) begin
          frame_sync_out <= 1'b0;
          active <= 1'b1;
        end
      end
      if (sample && cnt == adc_readout_pkg::LAST_BIT) begin
        frame_sync_out <= 1'b1;
      end
      if (fso_forced_low) begin
        frame_sync_out <= 1'b0;
      end
    end
  end

  // Registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= adc_readout_pkg::CTRL_RESET;
      mod_half <= adc_readout_pkg::MOD_HALF_RESET;
      period <= adc_readout_pkg::PERIOD_RESET;
      result <= adc_readout_pkg::RESULT_RESET;
    end else if (wr) begin
      if (hit_ctrl) begin
        ctrl <= next_ctrl;
      end
      if (hit_half) begin
        mod_half <= next_half_word[7:0];
      end
      if (hit_period) begin
        period <= next_period_word[15:0];
      end
      if (hit_result) begin
        result <= next_result;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || !enable) begin
      frames <= 16'h0000;
    end else if (launch && next_cnt == 16'h0000) begin
      frames <= frames + 16'h0001;
    end
  end

  wire [31:0] status_word = {frames, 12'h000, result_ready_out, frame_sync_out, active, lnk.sco};
  wire [31:0] read_mux = hit_ctrl ? ctrl : hit_half ? half_word : hit_period ? period_word :
    hit_result ? result : hit_status ? status_word : 32'h0000_0000;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack <= 1'b0;
      rdata <= 32'h0000_0000;
    end else begin
      ack <= req;
      rdata <= (req && !we_i) ? read_mux : rdata;
    end
  end

  assign ack_o = ack;
  assign dat_o = rdata;
  assign serial_clock_o = lnk.sco ^ polarity_sel;
  assign result_ready_out_o = result_ready_out;
  assign frame_sync_out_o = frame_sync_out;
  assign chain_marker_out_o = cmark;
  assign serial_data_out_o = serial_data_out;
endmodule

// ### testbench/adc_readout_chk.sv
// Port timing checker for the serial readout block
`timescale 1ns/100ps
module adc_readout_chk (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic ack_o,
  input wire logic serial_clock_o,
  input wire logic result_ready_out_o,
  input wire logic frame_sync_out_o,
  input wire logic chain_marker_out_o,
  input wire logic serial_data_out_o
);
  logic sc_q;
  logic sc_q2;
  logic rst_q;
  logic [7:0] rd_c, fs_c, cm_c, rr_c;
  // Strobes move one clock after the serial clock edge that launches them
  wire edg = sc_q != sc_q2;
  // Serial clock edges counted while each strobe is low, and since ready returned high
  always_ff @(posedge clk_i) begin
    sc_q <= serial_clock_o;
    sc_q2 <= sc_q;
    rst_q <= rst_i;
    rd_c <= (rst_i || result_ready_out_o) ? 8'h00 : rd_c + 8'(edg);
    fs_c <= (rst_i || frame_sync_out_o) ? 8'h00 : fs_c + 8'(edg);
    cm_c <= (rst_i || chain_marker_out_o) ? 8'h00 : cm_c + 8'(edg);
    rr_c <= (rst_i || !result_ready_out_o) ? 8'h00 : rr_c + 8'(edg);
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i || rst_q);
  AST_ACK_ONE: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("ack missing");
  AST_ACK_DROP: assert property (ack_o |=> !ack_o) else $error("ack too long");
  AST_READY_LEN: assert property ($rose(result_ready_out_o) |-> edg && rd_c == 8'h02)
    else $error("ready width");
  AST_READY_FALL: assert property ($fell(result_ready_out_o) |-> edg && !frame_sync_out_o)
    else $error("ready fall");
  AST_FSYNC_LEN: assert property ($rose(frame_sync_out_o) |-> edg && fs_c == 8'h3f)
    else $error("frame sync width");
  AST_CHAIN_START: assert property ($fell(chain_marker_out_o) |->
    edg && rr_c inside {8'h20, 8'h40, 8'h60}) else $error("chain spacing");
  AST_CHAIN_LEN: assert property ($rose(chain_marker_out_o) |-> edg && cm_c == 8'h02)
    else $error("chain width");
  AST_DATA_EDGE: assert property ($changed(serial_data_out_o) |-> edg)
    else $error("data off edge");
endmodule
bind adc_readout adc_readout_chk adc_readout_chk_inst (.clk_i(clk_i), .rst_i(rst_i),
  .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o), .serial_clock_o(serial_clock_o),
  .result_ready_out_o(result_ready_out_o), .frame_sync_out_o(frame_sync_out_o),
  .chain_marker_out_o(chain_marker_out_o), .serial_data_out_o(serial_data_out_o));

// ### testbench/host_rx_model.sv
// Host receiver that shifts in one word per frame
`timescale 1ns/100ps
module host_rx_model (
  input wire logic clk_i,
  input wire logic pol_i,
  input wire logic serial_clock_i,
  input wire logic frame_sync_n_i,
  input wire logic serial_data_i,
  output logic [31:0] word_o,
  output logic [7:0] frames_o
);
  logic sc_q = 1'b0;
  logic fs_q = 1'b1;
  logic [31:0] sh = 32'h0;
  logic [5:0] n = 6'h00;
  // Sample on falling edges, rising ones when polarity is swapped
  wire take = !fs_q && sc_q != serial_clock_i && serial_clock_i == pol_i;
  initial begin
    word_o = 32'h0;
    frames_o = 8'h00;
  end
  always @(posedge clk_i) begin
    sc_q <= serial_clock_i;
    fs_q <= frame_sync_n_i;
    if (fs_q) n <= 6'h00;
    if (take) begin
      sh <= {sh[30:0], serial_data_i};
      n <= n + 6'h01;
      if (n == 6'h1f) begin
        word_o <= {sh[30:0], serial_data_i};
        frames_o <= frames_o + 8'h01;
      end
    end
  end
endmodule

// ### testbench/testbench.sv
// Self-checking bench for the serial readout block
`timescale 1ns/100ps
module testbench;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, pol = 1'b0;
  logic [7:0] adr_i = 8'h00, frames, f0;
  logic [31:0] dat_i = 32'h0, dat_o, word, q;
  logic ack_o, sclk, rdy_n, fs_n, cm_n, ser_data;
  logic [31:0] ctl [4] = '{32'h103, 32'h109, 32'h305, 32'h113};
  int error_cnt = 0, n_checks = 0;
  initial forever #4 clk_i = ~clk_i;
  adc_readout adc_readout_inst (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(4'hf), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .frame_sync_in_i(1'b1), .serial_data_in_i(1'b1), .serial_clock_o(sclk),
    .result_ready_out_o(rdy_n), .frame_sync_out_o(fs_n), .chain_marker_out_o(cm_n),
    .serial_data_out_o(ser_data));
  host_rx_model host_rx_model_inst (.clk_i(clk_i), .pol_i(pol), .serial_clock_i(sclk),
    .frame_sync_n_i(fs_n), .serial_data_i(ser_data), .word_o(word), .frames_o(frames));
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask
  task check(input string s, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", s, e, g);
    end
  endtask
  task rd_chk(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    check("register", e, q);
  endtask
  task print_verdict;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #200000;
    error_cnt++;
    print_verdict();
  end
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk(adc_readout_pkg::OFS_CTRL, adc_readout_pkg::CTRL_RESET);
    rd_chk(adc_readout_pkg::OFS_MOD_HALF, 32'(adc_readout_pkg::MOD_HALF_RESET));
    rd_chk(adc_readout_pkg::OFS_PERIOD, 32'(adc_readout_pkg::PERIOD_RESET));
    wb(1'b1, 8'hfc, 32'hffff_ffff);
    rd_chk(8'hfc, 32'h0);
    // Half and full phases, swapped polarity, chained pulses, valid decimate-by-32
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_i);
      rst_i <= 1'b1;
      pol <= ctl[i][3];
      @(posedge clk_i);
      rst_i <= 1'b0;
      wb(1'b1, adc_readout_pkg::OFS_RESULT, 32'h9a5c_36e1 ^ 32'(i));
      wb(1'b1, adc_readout_pkg::OFS_CTRL, ctl[i]);
      f0 = frames;
      while (frames == f0) @(posedge clk_i);
      check("word", 32'h9a5c_36e1 ^ 32'(i), word);
    end
    wb(1'b1, adc_readout_pkg::OFS_CTRL, 32'h111);
    for (int k = 0; k < 4; k++) begin
      repeat (97) @(posedge clk_i);
      check("frame sync", 32'h0, {31'h0, fs_n});
    end
    print_verdict();
  end
endmodule
